/* tsw_defines.svh */
// constants for the time-division channel switch connection control
`ifndef TSW_DEFINES_SVH
`define TSW_DEFINES_SVH

`define TSW_REF_PERIOD_NS 100
`define TSW_HALF_CYC 1
`define TSW_BIT_CYC 4
`define TSW_BITS_PER_CH 8
`define TSW_SAMPLE_PHASE 2'h2
`define TSW_SHIFT_PHASE 2'h0
`define TSW_MAX_CH 128
`define TSW_CH_W 7
`define TSW_ST_W 4
`define TSW_IDX_W 11
`define TSW_DLY_TAPS 10
`define TSW_MAX_TAP 4'h9

// register byte addresses
`define TSW_A_CTRL 16'h0000
`define TSW_A_STATUS 16'h0004
`define TSW_A_FDMAP 16'h0008
`define TSW_A_OFF0 16'h000C
`define TSW_A_OFF3 16'h0018
`define TSW_CONN_SEL 3'h1
`define TSW_CTRL_RESET 2'h2

// measured frame delay write fields
`define TSW_FD_STREAM_LSB 12
`define TSW_FD_EDGE_BIT 11
`define TSW_FD_LOW_MSB 2

`endif

/* tsw_pkg.sv */
// shared types for the time-division channel switch
package tsw_pkg;

  typedef enum logic [1:0] {
    TSW_RATE_2M = 2'b00,
    TSW_RATE_4M = 2'b01,
    TSW_RATE_8M = 2'b10
  } tsw_rate_e;

  typedef struct packed {
    logic channel_loopback;
    logic const_delay;
    logic message_channel;
    logic control_serial_output;
    logic out_en;
    logic [3:0] source_stream_field;
    logic [6:0] source_channel_field;
  } tsw_conn_s;

  typedef struct packed {
    logic [2:0] stream_offset;
    logic half_period_latch_flag;
  } tsw_offset_s;

  typedef struct packed {
    logic [10:0] index;
    tsw_conn_s entry;
  } tsw_conn_wr_s;

endpackage : tsw_pkg

/* tsw_switch.sv */
// connection control core of the channel switch and its write fifo
`timescale 1ns/1ps
`include "tsw_defines.svh"

// small flip-flop fifo with valid and ready on both sides
module tsw_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // honest full and empty from the fill count
  assign in_ready = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : tsw_fifo

// switch core: input offset, data memory, connection memory, outputs
module tsw_switch #(
  parameter int NUM_STREAMS = 16,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_STREAMS-1:0] serial_input_stream,
  output logic [NUM_STREAMS-1:0] serial_output_stream,
  output logic [NUM_STREAMS-1:0] serial_output_oe,
  output logic control_serial_output,
  output logic frame_start
);
  localparam int S = NUM_STREAMS;
  localparam int CH_CYC = `TSW_BIT_CYC * `TSW_BITS_PER_CH;
  localparam int CYC_W = $clog2(CH_CYC);
  localparam int SLOT_SHIFT = CYC_W - $clog2(S);
  localparam int CONN_N = S * `TSW_MAX_CH;
  localparam int WR_W = $bits(tsw_pkg::tsw_conn_wr_s);
  localparam logic [CYC_W-1:0] LAST_CYC = CYC_W'(CH_CYC - 1);

  // channel count for the selected rate, less one
  function automatic logic [6:0] last_ch(input tsw_pkg::tsw_rate_e r);
    case (r)
      tsw_pkg::TSW_RATE_2M: last_ch = 7'h1F;
      tsw_pkg::TSW_RATE_4M: last_ch = 7'h3F;
      default: last_ch = 7'h7F;
    endcase
  endfunction : last_ch

  // connection memory index of a stream and channel
  function automatic logic [10:0] cm_idx(input logic [3:0] st,
                                         input logic [6:0] ch);
    cm_idx = {st, ch};
  endfunction : cm_idx

  // measured frame delay to offset setting
  function automatic tsw_pkg::tsw_offset_s fd_map(input logic edge_bit,
                                                  input logic [2:0] low);
    fd_map.stream_offset = low;
    fd_map.half_period_latch_flag = ~edge_bit;
  endfunction : fd_map

  // control and timing state
  tsw_pkg::tsw_rate_e rate_r;
  tsw_pkg::tsw_offset_s offset_r [0:S-1];
  tsw_pkg::tsw_conn_s conn_mem_r [0:CONN_N-1];
  logic [7:0] data_mem_r [0:1][0:CONN_N-1];
  logic [CYC_W-1:0] cyc_r;
  logic [6:0] ch_r;
  logic [6:0] next_ch;
  logic bank_r;
  logic [31:0] prdata_r;

  // input conditioning and datapath state
  logic [S-1:0] sync1_r;
  logic [S-1:0] sync2_r;
  logic [S-1:0] sync3_r;
  logic [S-1:0] in_stable_r;
  logic [`TSW_DLY_TAPS-1:0] dly_r [0:S-1];
  logic [7:0] rx_byte_r [0:S-1];
  logic [7:0] tx_sh_r [0:S-1];
  logic [7:0] tx_byte_r [0:S-1];
  logic [S-1:0] out_r;
  logic [S-1:0] oe_r;
  logic ctrl_r;
  logic frame_r;

  // bus decode
  logic setup_ph;
  logic access_ph;
  logic conn_hit;
  logic off_hit;
  logic mapped;
  logic [1:0] off_sel;
  logic [10:0] conn_index;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_drain;
  tsw_pkg::tsw_conn_wr_s fifo_in;
  tsw_pkg::tsw_conn_wr_s fifo_out;
  logic [3:0] fd_stream;

  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign conn_hit = (paddr[15:13] == `TSW_CONN_SEL);
  assign conn_index = paddr[12:2];
  assign off_hit = (paddr >= `TSW_A_OFF0) && (paddr <= `TSW_A_OFF3)
                   && (paddr[1:0] == 2'h0);
  assign off_sel = 2'((paddr - `TSW_A_OFF0) >> 2);
  assign mapped = (conn_hit && (32'(conn_index) < CONN_N))
                  || off_hit || paddr == `TSW_A_CTRL
                  || paddr == `TSW_A_STATUS || paddr == `TSW_A_FDMAP;
  assign fd_stream = pwdata[`TSW_FD_STREAM_LSB +: `TSW_ST_W];

  // entry writes wait in the fifo; a full fifo holds the bus
  assign fifo_in.index = conn_index;
  assign fifo_in.entry = tsw_pkg::tsw_conn_s'(pwdata[15:0]);
  assign pready = (access_ph && pwrite && conn_hit && mapped)
                  ? fifo_in_ready : 1'b1;
  assign pslverr = access_ph && !mapped;
  assign prdata = prdata_r;
  // entries are applied only at a channel boundary, so the fifo can fill
  assign fifo_drain = (cyc_r == LAST_CYC);

  tsw_fifo #(
    .WIDTH(WR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_data(fifo_in),
    .in_valid(access_ph && pwrite && conn_hit && mapped),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_drain)
  );

  // read data captured in the setup cycle, zero on unmapped
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata_r <= 32'h0000_0000;
      if (conn_hit && mapped) begin
        prdata_r[15:0] <= conn_mem_r[conn_index];
      end else if (off_hit) begin
        for (int k = 0; k < 4; k++) begin
          if (32'(off_sel) * 4 + k < S) begin
            prdata_r[k*4 +: 4] <= offset_r[32'(off_sel) * 4 + k];
          end
        end
      end else if (paddr == `TSW_A_CTRL) begin
        prdata_r[1:0] <= rate_r;
      end else if (paddr == `TSW_A_STATUS) begin
        prdata_r[`TSW_CH_W-1:0] <= ch_r;
        prdata_r[`TSW_CH_W] <= bank_r;
        prdata_r[`TSW_CH_W+1] <= fifo_out_valid;
        prdata_r[`TSW_CH_W+2] <= ~fifo_in_ready;
      end
    end
  end

  // rate and per-stream offset registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rate_r <= tsw_pkg::tsw_rate_e'(`TSW_CTRL_RESET);
      for (int k = 0; k < S; k++) begin
        offset_r[k] <= '0;
      end
    end else if (access_ph && pwrite) begin
      if (paddr == `TSW_A_CTRL) begin
        case (pwdata[1:0])
          2'h0: rate_r <= tsw_pkg::TSW_RATE_2M;
          2'h1: rate_r <= tsw_pkg::TSW_RATE_4M;
          default: rate_r <= tsw_pkg::TSW_RATE_8M;
        endcase
      end else if (paddr == `TSW_A_FDMAP && 32'(fd_stream) < S) begin
        offset_r[fd_stream] <= fd_map(pwdata[`TSW_FD_EDGE_BIT],
                                      pwdata[`TSW_FD_LOW_MSB:0]);
      end else if (off_hit) begin
        for (int k = 0; k < 4; k++) begin
          if (32'(off_sel) * 4 + k < S) begin
            offset_r[32'(off_sel) * 4 + k] <= pwdata[k*4 +: 4];
          end
        end
      end
    end
  end

  // connection memory, one entry per output stream and channel
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < CONN_N; k++) begin
        conn_mem_r[k] <= '0;
      end
    end else if (fifo_drain && fifo_out_valid) begin
      conn_mem_r[fifo_out.index] <= fifo_out.entry;
    end
  end

  // channel and frame timing
  assign next_ch = (ch_r == last_ch(rate_r)) ? 7'h00 : ch_r + 7'h01;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cyc_r <= '0;
      ch_r <= 7'h00;
      bank_r <= 1'b0;
      frame_r <= 1'b0;
    end else begin
      cyc_r <= (cyc_r == LAST_CYC) ? '0 : cyc_r + 1'b1;
      frame_r <= (cyc_r == LAST_CYC) && (next_ch == 7'h00);
      if (cyc_r == LAST_CYC) begin
        ch_r <= next_ch;
        if (next_ch == 7'h00) begin
          bank_r <= ~bank_r;
        end
      end
    end
  end
  assign frame_start = frame_r;

  // three-stage input sync; a change counts when stages two and three agree
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      in_stable_r <= '0;
    end else begin
      sync1_r <= serial_input_stream;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int k = 0; k < S; k++) begin
        if (sync2_r[k] == sync3_r[k]) begin
          in_stable_r[k] <= sync3_r[k];
        end
      end
    end
  end

  // per-stream delay line in half device clock periods
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < S; k++) begin
        dly_r[k] <= '0;
      end
    end else begin
      for (int k = 0; k < S; k++) begin
        dly_r[k] <= {dly_r[k][`TSW_DLY_TAPS-2:0], in_stable_r[k]};
      end
    end
  end

  // larger tap, shorter line: sampling moves later by half periods
  function automatic logic tap_bit(input logic [`TSW_DLY_TAPS-1:0] line,
                                   input tsw_pkg::tsw_offset_s off);
    logic [3:0] tap;
    tap = {off.stream_offset, off.half_period_latch_flag};
    if (tap > `TSW_MAX_TAP) begin
      tap = `TSW_MAX_TAP;
    end
    tap_bit = line[`TSW_MAX_TAP - tap];
  endfunction : tap_bit

  // receive shift, bits sampled msb first
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < S; k++) begin
        rx_byte_r[k] <= 8'h00;
      end
    end else if (cyc_r[1:0] == `TSW_SAMPLE_PHASE) begin
      for (int k = 0; k < S; k++) begin
        rx_byte_r[k] <= {rx_byte_r[k][6:0], tap_bit(dly_r[k], offset_r[k])};
      end
    end
  end

  // data memory write at channel end, two banks by frame parity
  always_ff @(posedge ref_clk) begin
    if (cyc_r == LAST_CYC) begin
      for (int k = 0; k < S; k++) begin
        if (conn_mem_r[cm_idx(4'(k), ch_r)].channel_loopback) begin
          data_mem_r[bank_r][cm_idx(4'(k), ch_r)] <= tx_byte_r[k];
        end else begin
          data_mem_r[bank_r][cm_idx(4'(k), ch_r)] <= rx_byte_r[k];
        end
      end
    end
  end

  // source byte for one entry: message byte or switched data
  function automatic logic [7:0] src_byte(input tsw_pkg::tsw_conn_s e,
                                          input logic [7:0] cur,
                                          input logic [7:0] prev,
                                          input logic early);
    if (e.message_channel) begin
      // low stream bit and seven channel bits go out whole
      src_byte = {e.source_stream_field[0], e.source_channel_field};
    end else if (!e.const_delay && early) begin
      // source channel already stored in this frame
      src_byte = cur;
    end else begin
      src_byte = prev;
    end
  endfunction : src_byte

  // output load at channel start, shift at each bit boundary
  always_ff @(posedge ref_clk or posedge rst) begin
    tsw_pkg::tsw_conn_s e;
    logic [6:0] sch;
    logic [10:0] sidx;
    logic [7:0] b;
    e = '0;
    sch = 7'h00;
    sidx = 11'h000;
    b = 8'h00;
    if (rst) begin
      for (int k = 0; k < S; k++) begin
        tx_sh_r[k] <= 8'h00;
        tx_byte_r[k] <= 8'h00;
      end
      out_r <= '0;
      oe_r <= '0;
    end else begin
      for (int k = 0; k < S; k++) begin
        if (cyc_r == '0) begin
          e = conn_mem_r[cm_idx(4'(k), ch_r)];
          sch = e.source_channel_field & last_ch(rate_r);
          sidx = cm_idx(e.source_stream_field, sch);
          b = src_byte(e, data_mem_r[bank_r][sidx],
                       data_mem_r[~bank_r][sidx], sch < ch_r);
          tx_sh_r[k] <= b;
          tx_byte_r[k] <= b;
          out_r[k] <= b[7];
          oe_r[k] <= e.out_en;
        end else if (cyc_r[1:0] == `TSW_SHIFT_PHASE) begin
          tx_sh_r[k] <= {tx_sh_r[k][6:0], 1'b0};
          out_r[k] <= tx_sh_r[k][6];
        end
      end
    end
  end
  assign serial_output_stream = out_r;
  assign serial_output_oe = oe_r;

  // control bit of the next channel, one slot per stream from stream 0
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= 1'b0;
    end else begin
      ctrl_r <= conn_mem_r[cm_idx(4'(cyc_r >> SLOT_SHIFT), next_ch)]
                .control_serial_output;
    end
  end
  assign control_serial_output = ctrl_r;

endmodule : tsw_switch

/* tsw_switch_sva.sv */
// assertions on the channel switch top ports
`timescale 1ns/1ps
module tsw_switch_chk #(
  parameter int NUM_STREAMS = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_STREAMS-1:0] serial_output_stream,
  input wire logic [NUM_STREAMS-1:0] serial_output_oe,
  input wire logic control_serial_output,
  input wire logic frame_start
);
  logic [4:0] ph_r;
  logic seen_r;
  logic [4:0] pos;
  logic ent;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // cycle inside the channel, locked to the frame pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ph_r <= 5'h00;
      seen_r <= 1'b0;
    end else begin
      ph_r <= pos + 5'h01;
      seen_r <= seen_r | frame_start;
    end
  end
  // channel cycle and entry window decode
  assign pos = frame_start ? 5'h00 : ph_r;
  assign ent = paddr[15:13] == 3'h1;

  property p_bit; seen_r && $changed(serial_output_stream) |-> pos[1:0] == 2'h1;
  endproperty
  a_bit: assert property (p_bit) else $error("data bit moved mid bit");
  property p_oe; seen_r && $changed(serial_output_oe) |-> pos == 5'h01;
  endproperty
  a_oe: assert property (p_oe) else $error("enable moved mid channel");
  property p_cso; seen_r && $changed(control_serial_output) |-> pos[0];
  endproperty
  a_cso: assert property (p_cso) else $error("control slot torn");
  property p_frm; seen_r && frame_start |-> ph_r == 5'h00 ##1 !frame_start;
  endproperty
  a_frm: assert property (p_frm) else $error("frame off channel");
  property p_err; pslverr |-> psel && penable && !ent;
  endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_stl; !pready |-> psel && pwrite && ent;
  endproperty
  a_stl: assert property (p_stl) else $error("stall on non entry");
  property p_wt; psel && penable && !pready |-> ##[1:40] pready;
  endproperty
  a_wt: assert property (p_wt) else $error("fifo never drained");
  property p_rst; $fell(rst) |-> !serial_output_oe && !control_serial_output;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs live at reset");
endmodule : tsw_switch_chk

bind tsw_switch tsw_switch_chk #(.NUM_STREAMS(NUM_STREAMS)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .serial_output_stream(serial_output_stream),
  .serial_output_oe(serial_output_oe),
  .control_serial_output(control_serial_output), .frame_start(frame_start));

/* tsw_far_model.sv */
// far-side serial stream source, one byte per stream and channel
`timescale 1ns/1ps
module tsw_far_model #(
  parameter int LEAD = 14
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic frame_start,
  input wire logic [1:0] rate,
  input wire logic [63:0] late,
  output logic [15:0] serial_input_stream
);
  logic [11:0] cnt_r;
  logic [11:0] pos;
  logic par_r;
  // frame cycle count and frame parity, locked to the frame pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 12'h000;
      par_r <= 1'b0;
    end else begin
      cnt_r <= pos + 12'h001;
      par_r <= par_r ^ frame_start;
    end
  end
  assign pos = frame_start ? 12'h000 : cnt_r;
  // bit at frame cycle p, msb first, lead covers sync and delay line
  // latency; frame parity in bit 0 tells frames apart
  function automatic logic fbit(input int s, input logic [11:0] p,
      input logic par);
    logic [7:0] b;
    b = ({3'(s), p[9:5]} ^ 8'hA5) ^ {7'h00, par};
    return b[3'h7 - p[4:2]];
  endfunction : fbit
  // each stream arrives late by its measured delay in cycles
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) serial_input_stream <= 16'h0000;
    else begin
      for (int s = 0; s < 16; s++) begin
        serial_input_stream[s] <= fbit(s, (pos + 12'(1 + LEAD)
          - 12'(late[4 * s +: 4])) & (12'(13'h0400 << rate) - 12'h001),
          par_r);
      end
    end
  end
endmodule : tsw_far_model

/* tb_tdm_switch_connection_control.sv */
// self-checking bench for the channel switch connection control
`timescale 1ns/1ps
`include "tsw_defines.svh"
module tb_tdm_switch_connection_control;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, control_serial_output, frame_start;
  logic [15:0] serial_input_stream, serial_output_stream, serial_output_oe;
  logic [1:0] rate = 2'h2;
  logic [63:0] late = 64'h0;
  logic [31:0] rng = 32'h00011FE2;
  logic [31:0] r;
  logic [31:0] exp_off [4] = '{default: 32'h0};
  logic [15:0] ent_q [20];
  logic [32:0] q_reg [$];
  logic [25:0] q_ser [$];
  logic [25:0] got;
  logic [11:0] fc = 12'h000;
  logic [11:0] ps;
  logic c4, c5;
  logic fp = 1'b0;
  int mismatches = 0;
  int n_tests = 0;
  int stall = 0;

  always #50 ref_clk = ~ref_clk;

  tsw_switch #(.NUM_STREAMS(16), .FIFO_DEPTH(16)) uut (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .serial_input_stream(serial_input_stream),
    .serial_output_stream(serial_output_stream),
    .serial_output_oe(serial_output_oe),
    .control_serial_output(control_serial_output), .frame_start(frame_start));

  tsw_far_model u_far (
    .ref_clk(ref_clk), .rst(rst), .frame_start(frame_start), .rate(rate),
    .late(late), .serial_input_stream(serial_input_stream));

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  function automatic logic [15:0] ea(input int st, input int ch);
    return 16'h2000 + 16'(4 * (st * 128 + ch));
  endfunction : ea

  function automatic logic [15:0] oa(input int k);
    return `TSW_A_OFF0 + 16'(4 * k);
  endfunction : oa

  function automatic tsw_pkg::tsw_conn_s cn(input logic lp, input logic cd,
      input logic mc, input logic cs, input logic oe, input logic [3:0] st,
      input logic [6:0] ch);
    return {lp, cd, mc, cs, oe, st, ch};
  endfunction : cn

  task automatic cmp_reg(input string nm, input logic [32:0] e,
      input logic [32:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_reg

  task automatic cmp_ser(input string nm, input logic [25:0] e,
      input logic [25:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_ser

  // one apb transfer, pready sampled at each rising edge of the access
  task automatic apb(input logic w, input logic [15:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      n++;
      @(posedge ref_clk);
    end
    stall += n;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] e,
      input logic perr);
    q_reg.push_back({perr, e});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic frames(input int n);
    repeat (n) @(posedge ref_clk iff frame_start === 1'b1);
  endtask : frames

  // expects control bit of stream 4 only, enable off then on; a switched
  // byte carries the parity of the frame it was taken in
  task automatic chk_ser(input logic [7:0] b, input logic sw,
      input logic cur);
    frames(2);
    q_ser.push_back({16'h0010, 1'b0, 1'b1, b ^ {7'h00, sw & (fp ^ cur)}});
    frames(1);
  endtask : chk_ser

  // read data against the oldest noted read
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && q_reg.size() > 0)
      cmp_reg("prdata", q_reg.pop_front(), {pslverr, prdata});
  end

  // stream 1 channel 5 byte, stream 1 enables of channels 4 and 5, control bits sent in channel 4
  assign ps = frame_start ? 12'h000 : fc;
  assign c4 = ps[11:5] == 7'h04;
  assign c5 = ps[11:5] == 7'h05;
  always @(posedge ref_clk) begin
    fc <= ps + 12'h001;
    fp <= fp ^ frame_start;
    if (c4 && ps[0]) got[10 + ps[4:1]] <= control_serial_output;
    if (c4 && ps[4:0] == 5'h10) got[9] <= serial_output_oe[1];
    if (c5 && ps[4:0] == 5'h10) got[8] <= serial_output_oe[1];
    if (c5 && ps[1:0] == 2'h2) got[7 - ps[4:2]] <= serial_output_stream[1];
    if (c5 && ps[4:0] == 5'h1F && q_ser.size() > 0)
      cmp_ser("serial", q_ser.pop_front(), got);
  end

  task automatic results;
    $display("counts: %0d compared, %0d mismatched", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  initial begin
    #(100 * 80000);
    mismatches++;
    $display("watchdog expired");
    results();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(`TSW_A_CTRL, 32'h2, 1'b0);
    for (int k = 0; k < 4; k++) rd(oa(k), 32'h0, 1'b0);
    rd(16'h1000, 32'h0, 1'b1);
    $display("test reset values done");
    for (int s = 0; s < 16; s++) begin
      r = xs();
      wr(`TSW_A_FDMAP, {16'h0000, 4'(s), r[11], 8'h00, r[2:0]});
      exp_off[s / 4][4 * (s % 4) +: 4] = {r[2:0], ~r[11]};
    end
    for (int k = 0; k < 4; k++) begin
      rd(oa(k), exp_off[k], 1'b0);
      wr(oa(k), 32'h0);
    end
    wr(`TSW_A_FDMAP, {16'h0000, 4'h2, 1'b1, 8'h00, 3'h2});
    late <= 64'h400;
    wr(`TSW_A_CTRL, 32'h0);
    rate <= 2'h0;
    $display("test offset mapping done");
    stall = 0;
    for (int c = 0; c < 20; c++) begin
      r = xs();
      ent_q[c] = r[15:0] & 16'hEFFF;
      wr(ea(6, c), {16'h0000, ent_q[c]});
    end
    cmp_reg("stall", 33'h1, {32'h0, stall > 0});
    frames(2);
    for (int c = 0; c < 20; c++) rd(ea(6, c), {16'h0, ent_q[c]}, 1'b0);
    $display("test entry fifo done");
    wr(ea(1, 5), {16'h0, cn(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 4'hB, 7'h5A)});
    wr(ea(4, 5), {16'h0, cn(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 7'h00)});
    chk_ser(8'hDA, 1'b0, 1'b0);
    $display("test message mode done");
    for (int k = 0; k < 3; k++) begin
      wr(`TSW_A_CTRL, 32'(k));
      rate <= 2'(k);
      wr(ea(1, 5), {16'h0, cn(1'b0, k[0], 1'b0, 1'b0, 1'b1, 4'h2,
        7'h03 | 7'(32'h20 << k))});
      chk_ser(8'hE6, 1'b1, ~k[0]);
    end
    $display("test switched rates done");
    wr(ea(3, 7), {16'h0, cn(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'h0, 7'h33)});
    wr(ea(1, 5), {16'h0, cn(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h3, 7'h07)});
    chk_ser(8'h33, 1'b0, 1'b0);
    $display("test loopback done");
    results();
  end
endmodule : tb_tdm_switch_connection_control
